// ### hdl/sbc_branch_unit.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RULE1] Signed less-than branch taken when first smaller
// [RULE2] Not taken: next PC is PC plus 4
// [RULE3] Taken: sign-extended offset added to next address
// [RULE4] Toolchain keeps offset low two bits clear
// [RULE5] Misaligned taken target raises an exception
// [RULE6] Two index fields select both compare operands
// [RULE7] Signed greater-than/less-equal come from operand swap
// [RULE8] Unsigned greater-than/less-equal come from operand swap
// [RULE9] Signed greater-or-equal branch is provided too
// [RULE10] Unsigned less-than branch is provided too
// [RULE11] Opcode 0x16, fields 31:27, 26:22, 21:6
module sbc_branch_unit (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              instr_valid,
    input  wire sbc_pkg::sbc_word_t instr_word,
    input  wire sbc_pkg::sbc_word_t instr_pc,
    input  wire logic              wr_en,
    input  wire sbc_pkg::sbc_idx_t  wr_idx,
    input  wire sbc_pkg::sbc_word_t wr_data,
    output logic                   branch_valid,
    output logic                   branch_taken,
    output sbc_pkg::sbc_word_t      next_pc,
    output logic                   misalign_exc
);
    import sbc_pkg::*;

    // Opcode recognition, shared by decode and checks
    function automatic logic is_cmp_branch(input sbc_op_t op);
        is_cmp_branch = (op == OP_BLT) || (op == OP_BGE) ||
                        (op == OP_BLTU) || (op == OP_BGEU);
    endfunction

    // Sign extension of the branch offset to a full word
    function automatic sbc_word_t sext_offset(input sbc_imm_t imm);
        sext_offset = {{(XLEN-IMM_W){imm[IMM_W-1]}}, imm};
    endfunction

    sbc_op_t   op_in;
    sbc_idx_t  first_operand_reg;
    sbc_idx_t  second_operand_reg;
    sbc_imm_t  branch_offset_field;
    sbc_word_t rd_a;
    sbc_word_t rd_b;

    logic      s1_valid_reg;
    logic      s1_valid_next;
    sbc_op_t   s1_op_reg;
    sbc_op_t   s1_op_next;
    sbc_imm_t  s1_imm_reg;
    sbc_imm_t  s1_imm_next;
    sbc_word_t s1_pc_reg;
    sbc_word_t s1_pc_next;

    logic      valid_reg;
    logic      valid_next;
    logic      taken_reg;
    logic      taken_next;
    sbc_word_t pc_reg;
    sbc_word_t pc_next;
    logic      exc_reg;
    logic      exc_next;

    logic      lt_signed;
    logic      lt_unsigned;
    logic      cond_met;
    sbc_word_t fall_pc;
    sbc_word_t target_pc;

    // Immediate-format field split
    always_comb begin
        op_in               = instr_word[OP_HI:OP_LO];         // [RULE11]
        first_operand_reg   = instr_word[FA_HI:FA_LO];         // [RULE11]
        second_operand_reg  = instr_word[FB_HI:FB_LO];         // [RULE11]
        branch_offset_field = instr_word[IMM_HI:IMM_LO];       // [RULE11]
    end

    // Operand fetch by the two index fields
    sbc_regfile #(
        .DEPTH (NUM_REGS),
        .WIDTH (XLEN),
        .IDX_W (REG_IDX_W)
    ) u_regfile (
        .clk       (clk),
        .rst       (rst),
        .wr_en     (wr_en),
        .wr_idx    (wr_idx),
        .wr_data   (wr_data),
        .rd_idx_a  (first_operand_reg),                        // [RULE6]
        .rd_idx_b  (second_operand_reg),                       // [RULE6]
        .rd_data_a (rd_a),
        .rd_data_b (rd_b)
    );

    // Decode stage next values; non-branch words are dropped
    always_comb begin
        s1_valid_next = instr_valid && is_cmp_branch(op_in);   // [RULE11]
        s1_op_next    = op_in;
        s1_imm_next   = branch_offset_field;
        s1_pc_next    = instr_pc;
    end

    // Decode stage registers
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_valid_reg <= 1'b0;
            s1_op_reg    <= OP_ZERO;
            s1_imm_reg   <= IMM_ZERO;
            s1_pc_reg    <= WORD_ZERO;
        end else begin
            s1_valid_reg <= s1_valid_next;
            s1_op_reg    <= s1_op_next;
            s1_imm_reg   <= s1_imm_next;
            s1_pc_reg    <= s1_pc_next;
        end
    end

    // Comparators, shared by all four branch kinds
    always_comb begin
        lt_signed   = $signed(rd_a) < $signed(rd_b);           // [RULE1]
        lt_unsigned = rd_a < rd_b;                             // [RULE10]
        unique case (s1_op_reg)
            OP_BLT:  cond_met = lt_signed;                     // [RULE1]
            OP_BGE:  cond_met = !lt_signed;                    // [RULE9]
            OP_BLTU: cond_met = lt_unsigned;                   // [RULE10]
            OP_BGEU: cond_met = !lt_unsigned;
            default: cond_met = 1'b0;
        endcase
    end

    // Next PC selection and alignment check
    always_comb begin
        fall_pc    = s1_pc_reg + PC_STEP;                      // [RULE2]
        target_pc  = fall_pc + sext_offset(s1_imm_reg);        // [RULE3]
        valid_next = s1_valid_reg;
        taken_next = s1_valid_reg && cond_met;
        pc_next    = pc_reg;
        exc_next   = 1'b0;
        if (s1_valid_reg) begin
            pc_next  = taken_next ? target_pc : fall_pc;       // [RULE2]
            exc_next = taken_next && (target_pc[1:0] != ALIGN_OK); // [RULE5]
        end
    end

    // Result registers
    always_ff @(posedge clk) begin
        if (rst) begin
            valid_reg <= 1'b0;
            taken_reg <= 1'b0;
            pc_reg    <= WORD_ZERO;
            exc_reg   <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            taken_reg <= taken_next;
            pc_reg    <= pc_next;
            exc_reg   <= exc_next;
        end
    end

    assign branch_valid = valid_reg;
    assign branch_taken = taken_reg;
    assign next_pc      = pc_reg;
    assign misalign_exc = exc_reg;

    // Result checks
    a_blt_signed_cmp: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        (s1_valid_reg && s1_op_reg == OP_BLT) |=>
        (branch_taken == ($signed($past(rd_a)) < $signed($past(rd_b)))))
        else $error("signed less-than outcome wrong");

    a_bge_signed_cmp: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        (s1_valid_reg && s1_op_reg == OP_BGE) |=>
        (branch_taken == ($signed($past(rd_a)) >= $signed($past(rd_b)))))
        else $error("signed greater-or-equal outcome wrong");

    a_bltu_unsigned_cmp: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        (s1_valid_reg && s1_op_reg == OP_BLTU) |=>
        (branch_taken == ($past(rd_a) < $past(rd_b))))
        else $error("unsigned less-than outcome wrong");

    a_bgeu_unsigned_cmp: assert property (@(posedge clk) disable iff (rst)
        (s1_valid_reg && s1_op_reg == OP_BGEU) |=>
        (branch_taken == ($past(rd_a) >= $past(rd_b))))
        else $error("unsigned greater-or-equal outcome wrong");

    a_fall_through_pc: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        (branch_valid && !branch_taken) |->
        (next_pc == $past(instr_pc, 2) + PC_STEP))
        else $error("fall-through PC is not PC plus 4");

    a_taken_target_pc: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        (branch_valid && branch_taken) |->
        (next_pc == $past(instr_pc, 2) + PC_STEP +
                    sext_offset($past(instr_word[IMM_HI:IMM_LO], 2))))
        else $error("taken target PC wrong");

    a_misalign_flag: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        branch_valid |->
        (misalign_exc == (branch_taken && (next_pc[1:0] != ALIGN_OK))))
        else $error("misaligned target flag wrong");

    a_no_stray_exc: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        (!branch_valid || !branch_taken) |-> !misalign_exc)
        else $error("exception without a taken branch");

    a_operand_index: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        (instr_valid && is_cmp_branch(op_in) &&
         first_operand_reg == second_operand_reg) |-> ##1 (rd_a == rd_b))
        else $error("operand fields do not select operands");

    sequence blt_accepted;
        instr_valid && (op_in == OP_BLT);
    endsequence

    sequence result_out;
        !branch_valid ##1 branch_valid;
    endsequence

    a_decode_latency: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        (blt_accepted and !s1_valid_reg) |-> ##1 result_out)
        else $error("blt result not two cycles after accept");

    a_non_branch_drop: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        (instr_valid && !is_cmp_branch(op_in)) |-> ##2 !branch_valid)
        else $error("non-branch word produced a result");

endmodule // sbc_branch_unit
`default_nettype wire

// ### inc/sbc_pkg.sv
`default_nettype none
// Shared constants and types for the compare-branch unit
package sbc_pkg;

    // Datapath and register file sizing
    localparam int XLEN      = 32;
    localparam int REG_IDX_W = 5;
    localparam int NUM_REGS  = 32;
    localparam int IMM_W     = 16;

    typedef logic [XLEN-1:0]      sbc_word_t;
    typedef logic [REG_IDX_W-1:0] sbc_idx_t;
    typedef logic [5:0]           sbc_op_t;
    typedef logic [IMM_W-1:0]     sbc_imm_t;

    // Compare-branch opcodes in the low six bits
    localparam sbc_op_t OP_BLT  = 6'h16;
    localparam sbc_op_t OP_BGE  = 6'h0E;
    localparam sbc_op_t OP_BLTU = 6'h36;
    localparam sbc_op_t OP_BGEU = 6'h2E;

    // Immediate-format field positions
    localparam int FA_HI  = 31;
    localparam int FA_LO  = 27;
    localparam int FB_HI  = 26;
    localparam int FB_LO  = 22;
    localparam int IMM_HI = 21;
    localparam int IMM_LO = 6;
    localparam int OP_HI  = 5;
    localparam int OP_LO  = 0;

    // Program counter stepping and alignment
    localparam sbc_word_t PC_STEP    = 32'h0000_0004;
    localparam logic [1:0] ALIGN_OK  = 2'h0;

    // Reset values
    localparam sbc_word_t WORD_ZERO  = 32'h0000_0000;
    localparam sbc_op_t   OP_ZERO    = 6'h00;
    localparam sbc_imm_t  IMM_ZERO   = 16'h0000;

    // Cycles from an accepted instruction to its result
    localparam int RESULT_LATENCY = 2;

endpackage : sbc_pkg
`default_nettype wire

// ### hdl/sbc_regfile.sv
`timescale 1ns/100ps
`default_nettype none
// General register file, two registered read ports, one write port
module sbc_regfile #(
    parameter int DEPTH = sbc_pkg::NUM_REGS,
    parameter int WIDTH = sbc_pkg::XLEN,
    parameter int IDX_W = sbc_pkg::REG_IDX_W
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [IDX_W-1:0] rd_idx_a,
    input  wire logic [IDX_W-1:0] rd_idx_b,
    output logic      [WIDTH-1:0] rd_data_a,
    output logic      [WIDTH-1:0] rd_data_b
);
    import sbc_pkg::*;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_a_reg;
    logic [WIDTH-1:0] rd_b_reg;
    logic [WIDTH-1:0] rd_a_next;
    logic [WIDTH-1:0] rd_b_next;

    // Storage write; contents are data and carry no reset
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Read lookup; a same-cycle write is not forwarded
    always_comb begin
        rd_a_next = mem[rd_idx_a];
        rd_b_next = mem[rd_idx_b];
    end

    // Read data registers
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_a_reg <= WIDTH'(WORD_ZERO);
            rd_b_reg <= WIDTH'(WORD_ZERO);
        end else begin
            rd_a_reg <= rd_a_next;
            rd_b_reg <= rd_b_next;
        end
    end

    assign rd_data_a = rd_a_reg;
    assign rd_data_b = rd_b_reg;

endmodule // sbc_regfile
`default_nettype wire

// ### tb/sbc_branch_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the compare-branch unit
module sbc_branch_unit_tb;
    import sbc_pkg::*;

    logic        clk;
    logic        rst;
    logic        instr_valid;
    sbc_word_t   instr_word;
    sbc_word_t   instr_pc;
    logic        wr_en;
    sbc_idx_t    wr_idx;
    sbc_word_t   wr_data;
    logic        branch_valid;
    logic        branch_taken;
    sbc_word_t   next_pc;
    logic        misalign_exc;
    sbc_word_t   rf [NUM_REGS];
    sbc_word_t   last_pc;
    logic [34:0] exp0;
    logic [34:0] exp1;
    int          error_cnt;
    int          tests_run;
    int          seed;
    sbc_op_t     ops [4] = '{OP_BLT, OP_BGE, OP_BLTU, OP_BGEU};

    sbc_branch_unit dut_u (
        .clk          (clk),
        .rst          (rst),
        .instr_valid  (instr_valid),
        .instr_word   (instr_word),
        .instr_pc     (instr_pc),
        .wr_en        (wr_en),
        .wr_idx       (wr_idx),
        .wr_data      (wr_data),
        .branch_valid (branch_valid),
        .branch_taken (branch_taken),
        .next_pc      (next_pc),
        .misalign_exc (misalign_exc)
    );

    // Core clock, 5 ns period
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected result as {valid, taken, misaligned, next pc}
    function automatic logic [34:0] model(input logic vi, input sbc_word_t w,
                                          input sbc_word_t pc);
        sbc_word_t a;
        sbc_word_t b;
        sbc_word_t tgt;
        logic      v;
        logic      t;
        a   = rf[w[FA_HI:FA_LO]];
        b   = rf[w[FB_HI:FB_LO]];
        tgt = pc + PC_STEP + {{16{w[IMM_HI]}}, w[IMM_HI:IMM_LO]};
        v   = vi;
        t   = 1'b0;
        case (w[OP_HI:OP_LO])
            OP_BLT:  t = $signed(a) < $signed(b);
            OP_BGE:  t = $signed(a) >= $signed(b);
            OP_BLTU: t = a < b;
            OP_BGEU: t = a >= b;
            default: v = 1'b0;
        endcase
        t = t & v;
        return {v, t, t && (tgt[1:0] != ALIGN_OK), t ? tgt : pc + PC_STEP};
    endfunction

    // One cycle: check the result due now, then drive new inputs
    task automatic step(input logic v, input sbc_word_t w, input sbc_word_t pc,
                        input logic we, input sbc_idx_t wi, input sbc_word_t wd);
        @(negedge clk);
        chk(32'(branch_valid), 32'(exp1[34]));
        if (exp1[34]) begin
            chk(32'(branch_taken), 32'(exp1[33]));
            chk(32'(misalign_exc), 32'(exp1[32]));
            chk(next_pc, exp1[31:0]);
            last_pc = exp1[31:0];
        end else begin
            chk(32'(branch_taken), 32'h0);
            chk(32'(misalign_exc), 32'h0);
            chk(next_pc, last_pc);
        end
        exp1 = exp0;
        exp0 = model(v, w, pc);
        if (we) begin
            rf[wi] = wd;
        end
        instr_valid = v;
        instr_word  = w;
        instr_pc    = pc;
        wr_en       = we;
        wr_idx      = wi;
        wr_data     = wd;
    endtask

    // Issue one branch with no register write
    task automatic br(input sbc_op_t op, input sbc_idx_t ia, input sbc_idx_t ib,
                      input sbc_imm_t imm, input sbc_word_t pc);
        step(1'b1, {ia, ib, imm, op}, pc, 1'b0, 5'h0, WORD_ZERO);
    endtask

    // Verdict and end of run
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #50000;
        error_cnt++;
        results;
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        sbc_word_t   w;
        sbc_word_t   pcr;
        error_cnt = 0;
        tests_run = 0;
        seed = 32'hCDCB;
        exp0 = '0;
        exp1 = '0;
        last_pc = WORD_ZERO;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = WORD_ZERO;
        instr_pc = WORD_ZERO;
        wr_en = 1'b0;
        wr_idx = 5'h0;
        wr_data = WORD_ZERO;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(next_pc, WORD_ZERO);
        // Fill the register file, then set corner operands
        for (int i = 0; i < NUM_REGS; i++) begin
            step(1'b0, WORD_ZERO, WORD_ZERO, 1'b1, sbc_idx_t'(i), $random(seed));
        end
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b1, 5'h1, 32'h8000_0000);
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b1, 5'h2, 32'h7FFF_FFFF);
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b1, 5'h3, 32'h1234_5678);
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b1, 5'h4, 32'h1234_5678);
        // Hand-picked corners, back to back
        br(OP_BLT, 5'h1, 5'h2, 16'h0010, 32'h0000_1000);
        br(OP_BLTU, 5'h1, 5'h2, 16'h0010, 32'h0000_1000);
        br(OP_BLT, 5'h2, 5'h1, 16'h8000, 32'h0000_2000);
        br(OP_BGE, 5'h3, 5'h4, 16'hFFFC, 32'h0000_0004);
        br(OP_BGE, 5'h2, 5'h1, 16'h0020, 32'h0000_6000);
        br(OP_BGEU, 5'h2, 5'h1, 16'h8000, 32'h0000_3000);
        br(OP_BLT, 5'h3, 5'h4, 16'h0010, 32'h0000_4000);
        br(OP_BLT, 5'h1, 5'h2, 16'h0006, 32'h0000_5000);
        br(OP_BLTU, 5'h2, 5'h1, 16'h7FFC, 32'hFFFF_FFF0);
        // Reset with a result in flight drops it
        br(OP_BGE, 5'h3, 5'h4, 16'h0010, 32'h0000_7000);
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b0, 5'h0, WORD_ZERO);
        rst = 1'b1;
        @(negedge clk);
        chk(32'(branch_valid), 32'h0);
        chk(32'(branch_taken), 32'h0);
        chk(32'(misalign_exc), 32'h0);
        chk(next_pc, WORD_ZERO);
        rst = 1'b0;
        exp0 = '0;
        exp1 = '0;
        last_pc = WORD_ZERO;
        // Random mix with writes landing on the same edge as reads
        for (int i = 0; i < 2000; i++) begin
            r = $random(seed);
            w = $random(seed);
            pcr = $random(seed);
            if (r[4:2] != 3'h0) begin
                w[OP_HI:OP_LO] = ops[r[1:0]];
            end
            if (r[6:5] != 2'h0) begin
                w[IMM_LO+1:IMM_LO] = 2'h0;
            end
            step(r[7] | r[8], w, {pcr[31:2], 2'h0}, r[9], r[14:10], $random(seed));
        end
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b0, 5'h0, WORD_ZERO);
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b0, 5'h0, WORD_ZERO);
        step(1'b0, WORD_ZERO, WORD_ZERO, 1'b0, 5'h0, WORD_ZERO);
        results;
    end
endmodule // sbc_branch_unit_tb
`default_nettype wire
